// File: core/thpc_pkg.sv
// Constants and carrier types for the touch host pointer command decoder.
// Assumes one 100 MHz clock (mclk) and a synchronous active-high reset.
package thpc_pkg;

   // command byte fields
   localparam int ADDR_MSB = 7;
   localparam int ADDR_LSB = 1;
   localparam int CONTINUOUS_PANEL_FLAG_BIT = 1;
   localparam int RW_BIT = 0;
   localparam int BYTE_BITS = 8;
   localparam logic [2:0] LAST_BIT = 3'h7;

   // command and register address map (7-bit)
   localparam logic [6:0] CFG_FIRST = 7'h00;
   localparam logic [6:0] CFG_LAST = 7'h0B;
   localparam logic [6:0] OPMODE_ADDR = 7'h0B;
   localparam logic [6:0] FIFO_ADDR = 7'h50;
   localparam logic [6:0] RES_FIRST = 7'h52;
   localparam logic [6:0] RES_LAST = 7'h5B;
   localparam logic [6:0] PANEL_FIRST = 7'h6A;
   localparam logic [6:0] PANEL_LAST = 7'h6F;
   localparam logic [6:0] MEAS_FIRST = 7'h70;
   localparam logic [6:0] MEAS_LAST = 7'h7F;

   // register file shape and reset
   localparam int CFG_REGS = 11;
   localparam int RES_BYTES = 10;
   localparam int OPMODE_AUTO_BIT = 0;
   localparam logic [7:0] CFG_RST = 8'h00;

   // end-of-file marker: event tag in the low two bits
   localparam logic [1:0] EOF_TAG = 2'h3;
   localparam logic [7:0] EOF_BYTE = {6'h00, EOF_TAG};

   // default link slave address (arbitrary value)
   localparam logic [6:0] SLAVE_ADDR_DEF = 7'h48;

   // command classes
   typedef enum logic [2:0]
   {
      CLS_RSVD = 3'h0,
      CLS_CFG = 3'h1,
      CLS_FIFO = 3'h2,
      CLS_RES = 3'h3,
      CLS_CONV = 3'h4
   } thpc_cls_t;

   // link engine states
   typedef enum logic [6:0]
   {
      S_IDLE = 7'h01,
      S_ADDR = 7'h02,
      S_ADDR_ACK = 7'h04,
      S_WR = 7'h08,
      S_WR_ACK = 7'h10,
      S_RD = 7'h20,
      S_RD_ACK = 7'h40
   } thpc_state_t;

   // decoded command byte
   typedef struct packed {
      thpc_cls_t cls;
      logic [6:0] addr;
      logic [6:0] dflt_ptr;
      logic continuous_panel_flag;
   } thpc_cmd_t;

   // conversion request towards the sequencer
   typedef struct packed {
      logic start;
      logic [6:0] cmd;
   } thpc_conv_t;

   // FIFO read side as seen by the decoder
   typedef struct packed {
      logic [7:0] data;
      logic empty;
      logic first;
      logic last;
   } thpc_fifo_in_t;

   // FIFO control pulses
   typedef struct packed {
      logic pop;
      logic claim;
      logic flush;
   } thpc_fifo_ctl_t;

   // whole state of the decoder
   typedef struct packed {
      thpc_state_t st;
      logic [2:0] cnt;
      logic [7:0] sh;
      logic rw;
      logic ack;
      logic hold;
      logic cmd_phase;
      logic conv_issued;
      logic [6:0] wr_idx;
      logic [6:0] ptr;
      logic oe;
      logic [CFG_REGS-1:0][7:0] cfg;
      thpc_conv_t conv;
      thpc_fifo_ctl_t fctl;
      logic mid_block;
      logic scl_q;
      logic sda_q;
   } thpc_core_t;

endpackage

// File: core/thpc_sync2.sv
// Two-flop synchroniser for pin-level inputs.
// Assumes inputs are asynchronous to mclk; idle level set by RST_VAL.
module thpc_sync2 #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
)
(
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stab;
   } thpc_sync_t;

   thpc_sync_t s_reg;
   thpc_sync_t s_next;

   // first stage feeds only the second stage
   always_comb
   begin
      s_next.meta = d;
      s_next.stab = s_reg.meta;
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         s_reg <= {RST_VAL, RST_VAL};
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign q = s_reg.stab;

endmodule

// File: core/thpc_cmd_decode.sv
// Combinational classifier for one received command byte.
// Assumes the caller registers its own use of the result.
module thpc_cmd_decode
   import thpc_pkg::*;
(
   // byte in
   input wire logic [7:0] byte_in,
   // decoded command
   output thpc_cmd_t cmd
);

   logic [6:0] a;
   logic [6:0] pair;

   assign a = byte_in[ADDR_MSB:ADDR_LSB];

   // classify address and pick the default readback location
   always_comb
   begin
      cmd.addr = a;
      cmd.continuous_panel_flag = byte_in[CONTINUOUS_PANEL_FLAG_BIT];
      cmd.cls = CLS_RSVD;
      cmd.dflt_ptr = a;
      pair = 7'h00;
      if (a <= CFG_LAST)
      begin
         cmd.cls = CLS_CFG;
      end
      else if (a == FIFO_ADDR)
      begin
         cmd.cls = CLS_FIFO;
      end
      else if (a >= RES_FIRST && a <= RES_LAST)
      begin
         cmd.cls = CLS_RES;
      end
      else if (a >= PANEL_FIRST && a <= PANEL_LAST)
      begin
         cmd.cls = CLS_CONV;
         pair = 7'((a - PANEL_FIRST) >> 1);
         cmd.dflt_ptr = 7'(RES_FIRST + {pair[5:0], 1'b0});
      end
      else if (a >= MEAS_FIRST)
      begin
         cmd.cls = CLS_CONV;
         cmd.dflt_ptr = 7'(RES_FIRST + {4'h0, a[3:2], 1'b0});
      end
   end

endmodule

// File: core/thpc_cmd_decoder.sv
// Serial command decoder and readback pointer of the touch controller.
// Assumes a two-wire link slave (clock and open-drain data) sampled by mclk,
// a conversion sequencer giving conv_busy, and a block FIFO beside it.
// Behaviour
// - a resumed read of the FIFO continues at the next unread block.
// - a result read stopped after the X low byte resumes at Y high byte.
// - each accepted conversion command loads its default result location.
// - an accepted conversion command always overwrites the pointer.
// - after a register write the pointer holds the last written register.
// - commands arriving while one still executes are discarded, pointer kept.
// - addresses 00h to 0Bh are status and configuration registers.
// - 50h is FIFO readback, 52h to 5Bh are result readback.
// - writes at 6Ah to 6Fh are panel setup commands.
// - writes at 70h to 7Fh are measurement commands.
// - command byte holds address in bits 7..1, bit 1 doubles as continuous flag.
// - each byte gets a ninth acknowledge bit; written bit 0 is ignored.
// - any number of register and data byte pairs per transfer.
// - configuration reads auto-increment from one location to the next.
// - with autonomous mode set, FIFO readback returns blocks oldest first.
// - FIFO blocks run on into the next block when read past the end.
// - an empty FIFO returns the end-of-file marker with event tag 11.
// - the FIFO readback address never auto-increments.
// - starting the first byte of a block marks the whole block read.
// - result reads increment only up to the auxiliary low byte, then repeat.
module thpc_cmd_decoder
   import thpc_pkg::*;
#(
   parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEF
)
(
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // serial link pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // conversion sequencer
   input wire logic conv_busy,
   output thpc_conv_t conv,
   // status and results
   input wire logic [7:0] status_in,
   input wire logic [RES_BYTES-1:0][7:0] results,
   // FIFO
   input thpc_fifo_in_t fifo_in,
   output thpc_fifo_ctl_t fifo_ctl,
   // configuration and pointer view
   output logic [CFG_REGS-1:0][7:0] cfg_regs,
   output logic auto_mode,
   output logic [6:0] read_pointer
);

   // refuse a general-call address
   if (SLAVE_ADDR == 7'h00)
   begin : g_bad_addr
      $error("slave address must not be zero");
   end

   thpc_core_t q_reg;
   thpc_core_t q_next;
   logic scl_s;
   logic sda_s;
   logic rise;
   logic fall;
   logic start_c;
   logic stop_c;
   logic [7:0] sh_in;
   logic [7:0] rd_byte;
   logic [3:0] rd_cfg_idx;
   logic [3:0] wr_cfg_idx;
   logic [3:0] res_idx;
   logic fifo_live;
   thpc_cmd_t cmd;

   // pin synchronisers, both idle high
   thpc_sync2 #(
      .W(2),
      .RST_VAL(2'h3)
   ) u_sync (
      .mclk(mclk),
      .reset(reset),
      .d({scl_in, sda_in}),
      .q({scl_s, sda_s})
   );

   // byte classification of the bits shifted in so far
   thpc_cmd_decode u_dec (
      .byte_in(sh_in),
      .cmd(cmd)
   );

   // link edges and bus conditions
   assign rise = scl_s & ~q_reg.scl_q;
   assign fall = ~scl_s & q_reg.scl_q;
   assign start_c = scl_s & q_reg.scl_q & q_reg.sda_q & ~sda_s;
   assign stop_c = scl_s & q_reg.scl_q & ~q_reg.sda_q & sda_s;
   assign sh_in = {q_reg.sh[6:0], sda_s};

   // register indices derived from pointer and write target
   assign rd_cfg_idx = 4'(q_reg.ptr - 7'h01);
   assign wr_cfg_idx = 4'(q_reg.wr_idx - 7'h01);
   assign res_idx = 4'(q_reg.ptr - RES_FIRST);
   assign auto_mode = q_reg.cfg[4'(OPMODE_ADDR - 7'h01)][OPMODE_AUTO_BIT];
   assign fifo_live = auto_mode & ~fifo_in.empty;

   // byte that the pointer selects for the next read
   always_comb
   begin
      rd_byte = 8'h00;
      if (q_reg.ptr == CFG_FIRST)
      begin
         rd_byte = status_in;
      end
      else if (q_reg.ptr <= CFG_LAST)
      begin
         rd_byte = q_reg.cfg[rd_cfg_idx];
      end
      else if (q_reg.ptr == FIFO_ADDR)
      begin
         rd_byte = fifo_live ? fifo_in.data : EOF_BYTE;
      end
      else if (q_reg.ptr >= RES_FIRST && q_reg.ptr <= RES_LAST)
      begin
         rd_byte = results[res_idx];
      end
   end

   // load a read byte, advance the pointer, pace the FIFO
   function automatic thpc_core_t load_byte(thpc_core_t s, logic [7:0] b,
                                            logic live, thpc_fifo_in_t f);
      thpc_core_t r;
      r = s;
      r.sh = b;
      r.cnt = 3'h0;
      r.oe = ~b[7];
      r.st = S_RD;
      if (s.ptr < CFG_LAST)
      begin
         r.ptr = 7'(s.ptr + 7'h01);
      end
      else if (s.ptr >= RES_FIRST && s.ptr < RES_LAST)
      begin
         r.ptr = 7'(s.ptr + 7'h01);
      end
      if (s.ptr == FIFO_ADDR && live)
      begin
         r.fctl.pop = 1'b1;
         r.fctl.claim = f.first;
         r.mid_block = ~f.last;
      end
      return r;
   endfunction

   // link engine and command interpreter
   always_comb
   begin
      q_next = q_reg;
      q_next.scl_q = scl_s;
      q_next.sda_q = sda_s;
      q_next.conv.start = 1'b0;
      q_next.fctl = '0;
      if (start_c || stop_c)
      begin
         // frame boundary: release the line, drop the rest of a begun block
         q_next.oe = 1'b0;
         q_next.hold = 1'b0;
         q_next.cnt = 3'h0;
         q_next.cmd_phase = 1'b1;
         q_next.conv_issued = 1'b0;
         q_next.st = start_c ? S_ADDR : S_IDLE;
         if (q_reg.mid_block)
         begin
            q_next.fctl.flush = 1'b1;
            q_next.mid_block = 1'b0;
         end
      end
      else
      begin
         case (q_reg.st)
            S_IDLE:
            begin
               q_next.oe = 1'b0;
            end
            S_ADDR:
            begin
               if (rise)
               begin
                  q_next.sh = sh_in;
                  q_next.cnt = 3'(q_reg.cnt + 3'h1);
                  if (q_reg.cnt == LAST_BIT)
                  begin
                     // read with no register phase reuses the pointer
                     q_next.rw = sh_in[RW_BIT];
                     q_next.ack = 1'b1;
                     q_next.st = (sh_in[7:1] == SLAVE_ADDR) ? S_ADDR_ACK : S_IDLE;
                  end
               end
            end
            S_ADDR_ACK:
            begin
               if (fall && !q_reg.hold)
               begin
                  q_next.oe = q_reg.ack;
                  q_next.hold = 1'b1;
               end
               else if (fall)
               begin
                  q_next.hold = 1'b0;
                  q_next.oe = 1'b0;
                  q_next.cnt = 3'h0;
                  q_next.st = S_WR;
                  if (q_reg.rw)
                  begin
                     q_next = load_byte(q_next, rd_byte, fifo_live, fifo_in);
                  end
               end
            end
            S_WR:
            begin
               if (rise)
               begin
                  q_next.sh = sh_in;
                  q_next.cnt = 3'(q_reg.cnt + 3'h1);
                  if (q_reg.cnt == LAST_BIT)
                  begin
                     q_next.st = S_WR_ACK;
                     q_next.ack = 1'b0;
                     if (!q_reg.cmd_phase)
                     begin
                        // data byte of a pair; status location takes no data
                        q_next.ack = 1'b1;
                        if (q_reg.wr_idx != CFG_FIRST)
                        begin
                           q_next.cfg[wr_cfg_idx] = sh_in;
                        end
                        q_next.ptr = q_reg.wr_idx;
                        q_next.cmd_phase = 1'b1;
                     end
                     else if (conv_busy || q_reg.conv_issued)
                     begin
                        q_next.ack = 1'b0;
                     end
                     else
                     begin
                        case (cmd.cls)
                           CLS_CFG:
                           begin
                              q_next.ack = 1'b1;
                              q_next.ptr = cmd.addr;
                              q_next.wr_idx = cmd.addr;
                              q_next.cmd_phase = 1'b0;
                           end
                           CLS_FIFO, CLS_RES:
                           begin
                              q_next.ack = 1'b1;
                              q_next.ptr = cmd.addr;
                           end
                           CLS_CONV:
                           begin
                              q_next.ack = 1'b1;
                              q_next.ptr = cmd.dflt_ptr;
                              q_next.conv.start = 1'b1;
                              q_next.conv.cmd = cmd.addr;
                              q_next.conv_issued = 1'b1;
                           end
                           default:
                           begin
                              q_next.ack = 1'b0;
                           end
                        endcase
                     end
                  end
               end
            end
            S_WR_ACK:
            begin
               if (fall && !q_reg.hold)
               begin
                  q_next.oe = q_reg.ack;
                  q_next.hold = 1'b1;
               end
               else if (fall)
               begin
                  q_next.hold = 1'b0;
                  q_next.oe = 1'b0;
                  q_next.cnt = 3'h0;
                  q_next.st = S_WR;
               end
            end
            S_RD:
            begin
               if (fall)
               begin
                  q_next.cnt = 3'(q_reg.cnt + 3'h1);
                  if (q_reg.cnt == LAST_BIT)
                  begin
                     q_next.oe = 1'b0;
                     q_next.hold = 1'b0;
                     q_next.st = S_RD_ACK;
                  end
                  else
                  begin
                     q_next.sh = {q_reg.sh[6:0], 1'b0};
                     q_next.oe = ~q_reg.sh[6];
                  end
               end
            end
            S_RD_ACK:
            begin
               if (rise)
               begin
                  // master acknowledge low means more data is wanted
                  q_next.hold = ~sda_s;
                  q_next.st = sda_s ? S_IDLE : S_RD_ACK;
               end
               else if (fall && q_reg.hold)
               begin
                  q_next.hold = 1'b0;
                  q_next = load_byte(q_next, rd_byte, fifo_live, fifo_in);
               end
            end
            default:
            begin
               q_next.st = S_IDLE;
               q_next.oe = 1'b0;
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         q_reg <= '0;
         q_reg.st <= S_IDLE;
         q_reg.cmd_phase <= 1'b1;
         q_reg.scl_q <= 1'b1;
         q_reg.sda_q <= 1'b1;
         q_reg.cfg <= {CFG_REGS{CFG_RST}};
      end
      else
      begin
         q_reg <= q_next;
      end
   end

   // outputs straight from the state register, sda_out tied low
   assign sda_out = 1'b0;
   assign sda_oe = q_reg.oe;
   assign conv = q_reg.conv;
   assign fifo_ctl = q_reg.fctl;
   assign cfg_regs = q_reg.cfg;
   assign read_pointer = q_reg.ptr;

endmodule

// File: tb/thpc_cmd_decoder_sva.sv
// Concurrent checks on the pins of the touch host pointer command decoder.
// Assumes mclk domain only, synchronous active-high reset; bound below.
module thpc_cmd_decoder_sva
   import thpc_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // watched ports
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic conv_busy,
   input wire thpc_conv_t conv,
   input wire thpc_fifo_in_t fifo_in,
   input wire thpc_fifo_ctl_t fifo_ctl,
   input wire logic [CFG_REGS-1:0][7:0] cfg_regs,
   input wire logic auto_mode,
   input wire logic [6:0] read_pointer
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);

   // default result location of a conversion command
   function automatic logic [6:0] dptr(input logic [6:0] c);
      if (c < MEAS_FIRST)
         return (c < 7'h6C) ? 7'h52 : (c < 7'h6E) ? 7'h54 : 7'h56;
      return 7'h52 + {4'h0, c[3:2], 1'b0};
   endfunction

   // busy held long enough to cover the decision cycle
   sequence s_busy_held;
      conv_busy [*5];
   endsequence
   // a first byte of a block taken from the FIFO
   sequence s_block_claim;
      fifo_ctl.claim;
   endsequence

   a_drain_only: assert property (!sda_out)
      else $error("data pin driven high");
   a_auto_flag: assert property (auto_mode == cfg_regs[10][OPMODE_AUTO_BIT])
      else $error("mode flag differs from mode register");
   a_busy_discard: assert property (s_busy_held |-> !conv.start)
      else $error("command started while busy");
   a_conv_ptr: assert property (conv.start |-> ##[0:2] read_pointer == dptr(conv.cmd))
      else $error("pointer not at default result location");
   a_start_pulse: assert property (conv.start |=> !conv.start)
      else $error("start longer than one cycle");
   a_conv_class: assert property (conv.start |-> conv.cmd inside {[PANEL_FIRST:MEAS_LAST]})
      else $error("start for a non-conversion command");
   a_ptr_legal: assert property (read_pointer <= CFG_LAST || read_pointer == FIFO_ADDR
      || read_pointer inside {[RES_FIRST:RES_LAST]})
      else $error("pointer at a reserved location");
   // the data pin may only move while the link clock is low
   a_oe_clk_low: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("data pin changed while link clock high");
   a_pop_gated: assert property (fifo_ctl.pop |-> $past(auto_mode) && !$past(fifo_in.empty))
      else $error("pop without data or outside autonomous mode");
   a_claim_first: assert property (s_block_claim |-> fifo_ctl.pop && $past(fifo_in.first))
      else $error("claim not on the first byte of a block");
endmodule

bind thpc_cmd_decoder thpc_cmd_decoder_sva chk_u (.mclk(mclk), .reset(reset),
   .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .conv_busy(conv_busy), .conv(conv), .fifo_in(fifo_in),
   .fifo_ctl(fifo_ctl), .cfg_regs(cfg_regs), .auto_mode(auto_mode),
   .read_pointer(read_pointer));

// File: tb/thpc_host_model.sv
// Link master model: two-wire clock and open-drain data, 80 ns bit period.
// Assumes the bench resolves the data wire and calls these tasks in turn.
module thpc_host_model
(
   // clock
   input wire logic mclk,
   // link pins
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   timeunit 1ns;
   timeprecision 100ps;

   // clock stands high, data released, outside frames
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // one bit: data set while clock low, sampled mid-high
   task automatic bit_io(input logic b, output logic r);
      @(posedge mclk) sda_low <= !b;
      tick(3);
      scl <= 1'b1;
      tick(2);
      r = sda;
      tick(2);
      scl <= 1'b0;
   endtask

   // start or repeated start, no register phase needed after it
   task automatic start();
      @(posedge mclk) sda_low <= 1'b0;
      tick(4);
      scl <= 1'b1;
      tick(4);
      sda_low <= 1'b1;
      tick(4);
      scl <= 1'b0;
   endtask

   task automatic stop();
      @(posedge mclk) sda_low <= 1'b1;
      tick(4);
      scl <= 1'b1;
      tick(4);
      sda_low <= 1'b0;
      tick(4);
   endtask

   // eight bits then a released ninth for the acknowledge
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], r);
      bit_io(1'b1, ack);
   endtask

   // eight bits in, then master acknowledge or not
   task automatic rbyte(input logic more, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, b[i]);
      bit_io(!more, r);
   endtask
endmodule

// File: tb/test_thpc_cmd_decoder.sv
// Self-checking bench for the touch host pointer command decoder.
// Assumes 100 MHz mclk, a link master model and a 12-byte block FIFO here.
module test_thpc_cmd_decoder
   import thpc_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;

   typedef struct {logic [6:0] a; logic [7:0] d;} thpc_row_t;
   thpc_row_t rows [4] = '{'{7'h01, 8'hA5}, '{7'h05, 8'h3C}, '{7'h0A, 8'hC3}, '{7'h03, 8'h0F}};
   logic [6:0] cv_cmd [7] = '{7'h6A, 7'h6C, 7'h6E, 7'h70, 7'h74, 7'h78, 7'h7C};
   logic [6:0] cv_ptr [7] = '{7'h52, 7'h54, 7'h56, 7'h52, 7'h54, 7'h56, 7'h58};
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic conv_busy = 1'b0;
   logic [7:0] status_in = 8'h5E;
   logic [RES_BYTES-1:0][7:0] results;
   logic scl, sda_low, sda_oe, auto_mode;
   wire logic sda;
   thpc_conv_t conv;
   thpc_fifo_in_t fin;
   thpc_fifo_ctl_t fctl;
   logic [CFG_REGS-1:0][7:0] cfg_regs;
   logic [6:0] read_pointer, p0;
   logic [7:0] got [8];
   logic [7:0] fmem [12];
   int fidx, starts, fail_count, compares;

   always #5 mclk = ~mclk;
   // open-drain wire with pull-up
   assign sda = !(sda_low | sda_oe);

   // block FIFO: four-byte blocks, begun block dropped on flush
   assign fin.data = (fidx < 12) ? fmem[fidx] : 8'h00;
   assign fin.empty = (fidx >= 12);
   assign fin.first = (fidx % 4 == 0);
   assign fin.last = (fidx % 4 == 3);
   always @(posedge mclk)
   begin
      if (reset) fidx <= 0;
      else if (fctl.flush && fidx % 4 != 0) fidx <= fidx - fidx % 4 + 4;
      else if (fctl.pop) fidx <= fidx + 1;
      if (conv.start) starts <= starts + 1;
   end

   thpc_host_model host_u (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));
   thpc_cmd_decoder dut_u (.mclk(mclk), .reset(reset), .scl_in(scl), .sda_in(sda),
      .sda_out(), .sda_oe(sda_oe), .conv_busy(conv_busy), .conv(conv),
      .status_in(status_in), .results(results), .fifo_in(fin), .fifo_ctl(fctl),
      .cfg_regs(cfg_regs), .auto_mode(auto_mode), .read_pointer(read_pointer));

   task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] seen);
      compares++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // write transfer: command byte, optional data byte
   task automatic wtx(input logic [7:0] c, input logic [7:0] d, input bit hasd, input logic nack);
      logic a;
      host_u.start();
      host_u.wbyte({SLAVE_ADDR_DEF, 1'b0}, a);
      host_u.wbyte(c, a);
      cmp("ack", {7'h00, nack}, {7'h00, a});
      if (hasd) host_u.wbyte(d, a);
      host_u.stop();
   endtask

   // streamlined read of n bytes
   task automatic rd(input int n);
      logic a;
      host_u.start();
      host_u.wbyte({SLAVE_ADDR_DEF, 1'b1}, a);
      for (int i = 0; i < n; i++)
         host_u.rbyte(i < n - 1, got[i]);
      host_u.stop();
   endtask

   task automatic conclude();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // watchdog against a hung link
   initial
   begin
      #400_000;
      fail_count++;
      conclude();
   end

   initial
   begin
      logic a;
      for (int i = 0; i < RES_BYTES; i++) results[i] = 8'hC0 + 8'(i);
      for (int i = 0; i < 12; i++) fmem[i] = 8'h90 + 8'(i);
      repeat (6) @(posedge mclk);
      reset <= 1'b0;
      repeat (4) @(posedge mclk);
      cmp("ptr", 8'h00, {1'b0, read_pointer});
      cmp("opmode", 8'h00, cfg_regs[10]);
      cmp("oe", 8'h00, {7'h00, sda_oe});
      $display("test reset done");
      foreach (rows[k])
      begin
         wtx({rows[k].a, 1'b0}, rows[k].d, 1, 1'b0);
         cmp("ptr", {1'b0, rows[k].a}, {1'b0, read_pointer});
         cmp("cfg", rows[k].d, cfg_regs[rows[k].a - 1]);
         rd(1);
         cmp("rd", rows[k].d, got[0]);
      end
      $display("test rows done");
      // two pairs in one transfer, bit 0 of a command set
      host_u.start();
      host_u.wbyte({SLAVE_ADDR_DEF, 1'b0}, a);
      host_u.wbyte(8'h05, a);
      host_u.wbyte(8'h11, a);
      host_u.wbyte(8'h06, a);
      host_u.wbyte(8'h22, a);
      host_u.stop();
      wtx(8'h00, 8'h00, 0, 1'b0);
      rd(4);
      cmp("rd", status_in, got[0]);
      cmp("rd", 8'hA5, got[1]);
      cmp("rd", 8'h11, got[2]);
      cmp("rd", 8'h22, got[3]);
      $display("test pairs done");
      wtx(8'hA4, 8'h00, 0, 1'b0);
      rd(2);
      rd(1);
      cmp("rd", results[2], got[0]);
      wtx(8'hB4, 8'h00, 0, 1'b0);
      rd(3);
      cmp("rd", results[9], got[1]);
      cmp("rd", results[9], got[2]);
      $display("test results done");
      foreach (cv_cmd[k])
      begin
         wtx({cv_cmd[k], 1'b0}, 8'h00, 0, 1'b0);
         cmp("starts", 8'(k + 1), 8'(starts));
         cmp("cmd", {1'b0, cv_cmd[k]}, {1'b0, conv.cmd});
         cmp("ptr", {1'b0, cv_ptr[k]}, {1'b0, read_pointer});
         rd(1);
         cmp("rd", results[cv_ptr[k] - 7'h52], got[0]);
      end
      $display("test conversions done");
      p0 = read_pointer;
      @(posedge mclk) conv_busy <= 1'b1;
      wtx(8'hE0, 8'h00, 0, 1'b1);
      @(posedge mclk) conv_busy <= 1'b0;
      cmp("starts", 8'h07, 8'(starts));
      cmp("ptr", {1'b0, p0}, {1'b0, read_pointer});
      wtx(8'h40, 8'h00, 0, 1'b1);
      wtx(8'hA2, 8'h00, 0, 1'b1);
      cmp("ptr", {1'b0, p0}, {1'b0, read_pointer});
      // a command after an accepted conversion, then a foreign address
      host_u.start();
      host_u.wbyte({SLAVE_ADDR_DEF, 1'b0}, a);
      host_u.wbyte(8'hF0, a);
      cmp("ack", 8'h00, {7'h00, a});
      host_u.wbyte(8'hA4, a);
      cmp("ack", 8'h01, {7'h00, a});
      host_u.stop();
      cmp("starts", 8'h08, 8'(starts));
      cmp("ptr", 8'h56, {1'b0, read_pointer});
      host_u.start();
      host_u.wbyte({~SLAVE_ADDR_DEF, 1'b0}, a);
      cmp("ack", 8'h01, {7'h00, a});
      host_u.stop();
      $display("test refusals done");
      wtx(8'h16, 8'h01, 1, 1'b0);
      cmp("auto", 8'h01, {7'h00, auto_mode});
      wtx(8'hA0, 8'h00, 0, 1'b0);
      rd(6);
      for (int i = 0; i < 6; i++) cmp("fifo", fmem[i], got[i]);
      rd(2);
      cmp("fifo", fmem[8], got[0]);
      cmp("fifo", fmem[9], got[1]);
      cmp("ptr", {1'b0, FIFO_ADDR}, {1'b0, read_pointer});
      rd(1);
      cmp("fifo", EOF_BYTE, got[0]);
      $display("test fifo done");
      conclude();
   end
endmodule
